// >>> rtl/tsr_target.sv
// target-side serial protocol engine for the sensor register file
`timescale 1ns/1ps
`include "tsr_defines.svh"

module tsr_target (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // serial link pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // address straps
    input wire logic [`TSR_ADDR_W-1:0] target_addr_i,
    // register read side
    output logic [`TSR_BYTE_W-1:0] reg_ptr_o,
    input wire logic [`TSR_WORD_W-1:0] rd_word_i,
    output logic read_done_o,
    // register write side
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [`TSR_BYTE_W-1:0] wr_ptr_o,
    output logic wr_lsb_o,
    output logic [`TSR_BYTE_W-1:0] wr_data_o,
    // status
    output logic busy_o
);

    // ****************************************************
    // pin synchronisers and edge detection
    // ****************************************************
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic [`TSR_ADDR_W-1:0] addr_m_q, addr_s_q;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            addr_m_q <= '0;
            addr_s_q <= '0;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            addr_m_q <= target_addr_i;
            addr_s_q <= addr_m_q;
        end
    end

    wire scl_rise = scl_s_q && !scl_p_q;
    wire scl_fall = !scl_s_q && scl_p_q;
    wire scl_high = scl_s_q && scl_p_q;
    // start and repeated start share one waveform
    wire start_det = scl_high && sda_p_q && !sda_s_q;
    wire stop_det = scl_high && !sda_p_q && sda_s_q;

    // ****************************************************
    // protocol state
    // ****************************************************
    tsr_pkg::tsr_state_t state_q;
    logic [2:0] bit_cnt_q;
    logic [`TSR_BYTE_W-1:0] rx_q;
    logic got8_q;
    logic rnw_q;
    logic ptr_phase_q;
    logic wr_lsb_q;
    logic rd_lsb_q;
    logic host_ack_q;
    logic [`TSR_WORD_W-1:0] tx_q;
    logic sda_low_q;
    logic [`TSR_BYTE_W-1:0] ptr_q;
    logic read_done_q;

    wire receiving = (state_q == tsr_pkg::TSR_ADDR) || (state_q == tsr_pkg::TSR_WR_BYTE);
    wire addr_match = (rx_q[7:1] == addr_s_q);
    wire byte_ready = receiving && got8_q && scl_fall;

    // written bytes after the pointer byte go through the buffer
    logic buf_in_ready;
    wire push_req = byte_ready && (state_q == tsr_pkg::TSR_WR_BYTE) && !ptr_phase_q;
    wire push = push_req && buf_in_ready;

    tsr_buf u_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(push),
        .in_ready_o(buf_in_ready),
        .in_data_i({ptr_q, wr_lsb_q, rx_q}),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o({wr_ptr_o, wr_lsb_o, wr_data_o})
    );

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= tsr_pkg::TSR_IDLE;
            bit_cnt_q <= '0;
            rx_q <= '0;
            got8_q <= 1'b0;
            rnw_q <= 1'b0;
            ptr_phase_q <= 1'b0;
            wr_lsb_q <= 1'b0;
            rd_lsb_q <= 1'b0;
            host_ack_q <= 1'b0;
            tx_q <= '0;
            sda_low_q <= 1'b0;
            ptr_q <= `TSR_PTR_RST;
            read_done_q <= 1'b0;
        end else begin
            read_done_q <= 1'b0;
            if (start_det) begin
                state_q <= tsr_pkg::TSR_ADDR;
                bit_cnt_q <= '0;
                got8_q <= 1'b0;
                sda_low_q <= 1'b0;
            end else if (stop_det) begin
                state_q <= tsr_pkg::TSR_IDLE;
                sda_low_q <= 1'b0;
            end else begin
                if (receiving && scl_rise) begin
                    rx_q <= {rx_q[6:0], sda_s_q};
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                    got8_q <= (bit_cnt_q == `TSR_BIT_LAST);
                end
                unique case (state_q)
                    tsr_pkg::TSR_IDLE, tsr_pkg::TSR_IGNORE: begin
                        sda_low_q <= 1'b0;
                    end
                    tsr_pkg::TSR_ADDR: begin
                        if (byte_ready) begin
                            got8_q <= 1'b0;
                            if (addr_match) begin
                                rnw_q <= rx_q[0];
                                ptr_phase_q <= 1'b1;
                                wr_lsb_q <= 1'b0;
                                rd_lsb_q <= 1'b0;
                                tx_q <= rd_word_i;
                                sda_low_q <= 1'b1;
                                state_q <= tsr_pkg::TSR_ADDR_ACK;
                            end else begin
                                state_q <= tsr_pkg::TSR_IGNORE;
                            end
                        end
                    end
                    tsr_pkg::TSR_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= '0;
                            if (rnw_q) begin
                                sda_low_q <= !tx_q[15];
                                state_q <= tsr_pkg::TSR_RD_BYTE;
                            end else begin
                                sda_low_q <= 1'b0;
                                state_q <= tsr_pkg::TSR_WR_BYTE;
                            end
                        end
                    end
                    tsr_pkg::TSR_WR_BYTE: begin
                        if (byte_ready) begin
                            got8_q <= 1'b0;
                            if (ptr_phase_q) begin
                                ptr_q <= rx_q;
                                ptr_phase_q <= 1'b0;
                                sda_low_q <= 1'b1;
                                state_q <= tsr_pkg::TSR_WR_ACK;
                            end else if (buf_in_ready) begin
                                wr_lsb_q <= !wr_lsb_q;
                                sda_low_q <= 1'b1;
                                state_q <= tsr_pkg::TSR_WR_ACK;
                            end else begin
                                // no room: leave the slot high to report failure
                                state_q <= tsr_pkg::TSR_IGNORE;
                            end
                        end
                    end
                    tsr_pkg::TSR_WR_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_q <= '0;
                            sda_low_q <= 1'b0;
                            state_q <= tsr_pkg::TSR_WR_BYTE;
                        end
                    end
                    tsr_pkg::TSR_RD_BYTE: begin
                        if (scl_fall) begin
                            if (bit_cnt_q == `TSR_BIT_LAST) begin
                                bit_cnt_q <= '0;
                                sda_low_q <= 1'b0;
                                state_q <= tsr_pkg::TSR_RD_ACK;
                            end else begin
                                bit_cnt_q <= bit_cnt_q + 3'h1;
                                tx_q <= {tx_q[14:0], 1'b0};
                                sda_low_q <= !tx_q[14];
                            end
                        end
                    end
                    tsr_pkg::TSR_RD_ACK: begin
                        if (scl_rise) begin
                            host_ack_q <= !sda_s_q;
                        end
                        if (scl_fall) begin
                            if (host_ack_q) begin
                                rd_lsb_q <= !rd_lsb_q;
                                state_q <= tsr_pkg::TSR_RD_BYTE;
                                if (rd_lsb_q) begin
                                    tx_q <= rd_word_i;
                                    sda_low_q <= !rd_word_i[15];
                                end else begin
                                    tx_q <= {tx_q[14:0], 1'b0};
                                    sda_low_q <= !tx_q[14];
                                end
                            end else begin
                                // not-acknowledge ends the read after any byte count
                                read_done_q <= 1'b1;
                                state_q <= tsr_pkg::TSR_IGNORE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign sda_o = 1'b0;
    assign sda_oe_o = sda_low_q;
    assign reg_ptr_o = ptr_q;
    assign read_done_o = read_done_q;
    assign busy_o = (state_q != tsr_pkg::TSR_IDLE);

endmodule

// >>> rtl/tsr_defines.svh
// constants for the sensor register serial access block
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH

`define TSR_ADDR_W 7
`define TSR_BYTE_W 8
`define TSR_WORD_W 16
`define TSR_BIT_LAST 3'h7
`define TSR_PTR_RST 8'h00
`define TSR_ENTRY_W 17
`define TSR_BUF_DEPTH 2
`define TSR_LINK_PERIOD_NS 400

`endif

// >>> rtl/tsr_pkg.sv
// types shared by the sensor register serial access block
package tsr_pkg;

    typedef enum logic [2:0] {
        TSR_IDLE,
        TSR_ADDR,
        TSR_ADDR_ACK,
        TSR_WR_BYTE,
        TSR_WR_ACK,
        TSR_RD_BYTE,
        TSR_RD_ACK,
        TSR_IGNORE
    } tsr_state_t;

endpackage

// >>> rtl/tsr_buf.sv
// two-entry valid/ready buffer for written register bytes
`timescale 1ns/1ps
`include "tsr_defines.svh"

module tsr_buf #(
    parameter int WIDTH = `TSR_ENTRY_W,
    parameter int DEPTH = `TSR_BUF_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [IW-1:0] wr_idx_q;
    logic [IW-1:0] rd_idx_q;
    logic [IW:0] cnt_q;

    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    assign in_ready_o = (cnt_q != (IW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_idx_q];

    function automatic logic [IW-1:0] next_idx(input logic [IW-1:0] idx);
        next_idx = (idx == IW'(DEPTH - 1)) ? '0 : idx + IW'(1);
    endfunction

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_idx_q <= '0;
            rd_idx_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_idx_q <= next_idx(wr_idx_q);
            end
            if (pop) begin
                rd_idx_q <= next_idx(rd_idx_q);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + (IW+1)'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - (IW+1)'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_idx_q] <= in_data_i;
        end
    end

endmodule

// >>> test/tsr_target_assertions.sv
// concurrent checks on the serial target ports
`timescale 1ns/1ps
module tsr_target_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // link and user side
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [6:0] target_addr_i,
    input wire logic [7:0] reg_ptr_o,
    input wire logic [15:0] rd_word_i,
    input wire logic read_done_o,
    input wire logic wr_valid_o,
    input wire logic wr_ready_i,
    input wire logic [7:0] wr_ptr_o,
    input wire logic wr_lsb_o,
    input wire logic [7:0] wr_data_o,
    input wire logic busy_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_start;
        scl_i && $past(scl_i) && $fell(sda_i);
    endsequence
    sequence s_stop;
        scl_i && $past(scl_i) && $rose(sda_i);
    endsequence
    sequence s_oe_move;
        $changed(sda_oe_o);
    endsequence
    AST_BUSY_START: assert property (s_start |-> ##[1:6] busy_o)
        else $error("busy did not follow a start");
    AST_STOP_FREE: assert property (s_stop |-> ##[1:6] (!busy_o && !sda_oe_o))
        else $error("bus not freed after a stop");
    AST_OE_LOW_ONLY: assert property (s_oe_move |-> !scl_i)
        else $error("data drive changed while clock high");
    AST_OE_HOLD: assert property (s_oe_move |=> $stable(sda_oe_o)[*4])
        else $error("data drive did not stand");
    AST_IDLE_QUIET: assert property (!busy_o |-> !sda_oe_o)
        else $error("data driven on a free bus");
    AST_DONE_ONE: assert property (read_done_o |=> !read_done_o)
        else $error("read done longer than one cycle");
    AST_DONE_QUIET: assert property (read_done_o |-> busy_o && !sda_oe_o)
        else $error("read done while driving or idle");
    AST_PTR_RESET: assert property ($past(sys_rst_i) |-> reg_ptr_o == 8'h00)
        else $error("pointer not cleared by reset");
    AST_WR_HOLD: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable({wr_lsb_o, wr_ptr_o, wr_data_o}))
        else $error("buffered byte lost while stalled");
    AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
        else $error("data pin drive value not low");
endmodule

bind tsr_target tsr_target_assertions u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .target_addr_i(target_addr_i), .reg_ptr_o(reg_ptr_o), .rd_word_i(rd_word_i),
    .read_done_o(read_done_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
    .wr_ptr_o(wr_ptr_o), .wr_lsb_o(wr_lsb_o), .wr_data_o(wr_data_o), .busy_o(busy_o));

// >>> test/tsr_host.sv
// behavioural bus host: makes every clock, pulls the data line open drain
`timescale 1ns/1ps
module tsr_host (
    // bus lines
    output logic scl_o,
    output logic sda_pull_o,
    input wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    // same shape opens from idle or repeats after a byte
    task automatic start;
        #100 sda_pull_o = 1'b0;
        #100 scl_o = 1'b1;
        #100 sda_pull_o = 1'b1;
        #100 scl_o = 1'b0;
    endtask
    task automatic stop;
        #100 sda_pull_o = 1'b1;
        #100 scl_o = 1'b1;
        #100 sda_pull_o = 1'b0;
        #100;
    endtask
    // data set in the low half, sampled in the high half
    task automatic bit_slot(input logic drv, output logic smp);
        #100 sda_pull_o = !drv;
        #100 scl_o = 1'b1;
        #100 smp = sda_i;
        #100 scl_o = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
        output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_slot(tx[i], rx[i]);
        end
        bit_slot(ack, ak);
    endtask
endmodule

// >>> test/tb_tsr_target.sv
// self-checking bench for the serial target
`timescale 1ns/1ps
module tb_tsr_target;
    logic clk_i, sys_rst_i, wr_ready_i, sda_o, sda_oe_o, read_done_o;
    logic wr_valid_o, wr_lsb_o, busy_o, rnd_rdy, rdy_fix, ak;
    logic [6:0] addr;
    logic [7:0] salt, p, d, rx, reg_ptr_o, wr_ptr_o, wr_data_o;
    logic [15:0] rd_word_i;
    logic [16:0] exp_q[$];
    logic [16:0] want;
    wire scl, sda_pull, sda;
    int err_count, tests_run, dones;
    assign sda = !(sda_pull | sda_oe_o);
    // register file: word derived from the pointer
    assign rd_word_i = {reg_ptr_o ^ 8'hA5, reg_ptr_o + salt};
    tsr_target uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .target_addr_i(addr), .reg_ptr_o(reg_ptr_o),
        .rd_word_i(rd_word_i), .read_done_o(read_done_o), .wr_valid_o(wr_valid_o),
        .wr_ready_i(wr_ready_i), .wr_ptr_o(wr_ptr_o), .wr_lsb_o(wr_lsb_o),
        .wr_data_o(wr_data_o), .busy_o(busy_o));
    tsr_host host (.scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input logic [16:0] seen, input logic [16:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic xb(input logic [7:0] tx, input logic hack, input logic exp_ak);
        host.xfer(tx, hack, rx, ak);
        check(17'(ak), 17'(exp_ak));
    endtask
    task automatic open_wr(input logic [7:0] ptr);
        host.start();
        xb({addr, 1'b0}, 1'b1, 1'b0);
        xb(ptr, 1'b1, 1'b0);
    endtask
    always @(posedge clk_i) begin
        if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
            want = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            check({wr_lsb_o, wr_ptr_o, wr_data_o}, want);
        end
        if (read_done_o === 1'b1) begin
            dones++;
        end
    end
    // consumer ready: random while stalling is wanted, otherwise a fixed level
    always @(negedge clk_i) begin
        wr_ready_i <= rnd_rdy ? 1'($urandom) : rdy_fix;
    end
    initial begin
        #500000;
        err_count++;
        close_out();
    end
    initial begin
        void'($urandom(32'hBC10));
        sys_rst_i = 1'b1;
        rdy_fix = 1'b1;
        rnd_rdy = 1'b0;
        addr = 7'($urandom);
        salt = 8'($urandom);
        repeat (5) @(negedge clk_i);
        sys_rst_i = 1'b0;
        // read after reset, upper byte only
        host.start();
        xb({addr, 1'b1}, 1'b1, 1'b0);
        xb(8'hFF, 1'b1, 1'b1);
        check(17'(rx), 17'h000A5);
        host.stop();
        check(17'(dones), 17'h00001);
        $display("test single byte read done");
        // pointer then three bytes, consumer stalling at random
        p = 8'($urandom_range(255, 1));
        rnd_rdy = 1'b1;
        open_wr(p);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            exp_q.push_back({i[0], p, d});
            xb(d, 1'b1, 1'b0);
        end
        host.stop();
        repeat (20) @(negedge clk_i);
        rnd_rdy = 1'b0;
        @(negedge clk_i);
        rdy_fix = 1'b1;
        repeat (10) @(negedge clk_i);
        check(17'(reg_ptr_o), 17'(p));
        check(17'(exp_q.size()), 17'h0);
        $display("test write done");
        // pointer write, repeated start, two byte read
        p = p ^ 8'h3C;
        open_wr(p);
        host.start();
        xb({addr, 1'b1}, 1'b1, 1'b0);
        xb(8'hFF, 1'b0, 1'b0);
        check(17'(rx), 17'(p ^ 8'hA5));
        xb(8'hFF, 1'b1, 1'b1);
        check(17'(rx), 17'(8'(p + salt)));
        host.stop();
        check(17'(dones), 17'h00002);
        $display("test two byte read done");
        // another target address is left alone
        host.start();
        xb({addr ^ 7'h01, 1'b0}, 1'b1, 1'b1);
        xb(~p, 1'b1, 1'b1);
        host.stop();
        check(17'(reg_ptr_o), 17'(p));
        $display("test foreign address done");
        // consumer stalled: two bytes fit, the third is refused
        rdy_fix = 1'b0;
        open_wr(p);
        for (int i = 0; i < 3; i++) begin
            d = 8'($urandom);
            if (i < 2) exp_q.push_back({i[0], p, d});
            xb(d, 1'b1, i == 2);
        end
        host.stop();
        check(17'(wr_valid_o), 17'h00001);
        rdy_fix = 1'b1;
        repeat (10) @(negedge clk_i);
        check(17'(exp_q.size()), 17'h0);
        $display("test full buffer done");
        close_out();
    end
endmodule
